// File: hw/bmd_discard_table.sv
/*
  Buffer manager reset status and random-discard table, behind an AHB-Lite slave.
  Assumes a single master, word transfers only, and all inputs on clk_in.
*/
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`include "bmd_params.svh"

module bmd_discard_table import bmd_pkg::*; #(
  parameter int INIT_CYCLES = `BMD_INIT_CYCLES
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_n_in,
  // AHB-Lite slave.
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Fabric reset request from the switch core.
  input wire logic fabric_reset_in,
  // Ingress meter side.
  input wire logic pkt_valid_in,
  input wire logic pkt_yellow_in,
  input wire logic [7:0] port_buf_count_in,
  output logic drop_valid_out,
  output logic drop_out,
  // Interrupt.
  output logic irq_out
);

  localparam int INIT_LAST = INIT_CYCLES - 1;

  // Bus phase state.
  logic ap_valid_r, ap_valid_nxt;
  logic ap_write_r, ap_write_nxt;
  logic [13:0] ap_idx_r, ap_idx_nxt;
  logic rd_done_r, rd_done_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  // Registers.
  logic [4:0] cmd_r, cmd_nxt;
  bmd_prob_type wdata_r, wdata_nxt;
  bmd_prob_type rdata_r, rdata_nxt;
  logic enable_r, enable_nxt;
  logic [2:0] irq_stat_r, irq_stat_nxt;
  logic [2:0] irq_mask_r, irq_mask_nxt;
  // Initialisation sequencer.
  bmd_init_state_type init_state_r, init_state_nxt;
  logic [15:0] init_cnt_r, init_cnt_nxt;
  // Meter path.
  logic [9:0] lfsr_r, lfsr_nxt;
  logic drop_valid_r, drop_valid_nxt;
  logic drop_r, drop_nxt;
  // Table storage and its write port.
  bmd_prob_type table_mem [16];
  logic tbl_we;
  logic [3:0] tbl_waddr;
  // Shared decode terms.
  logic take, wr_cmt, cmd_hit, ready, init_ev;
  logic [3:0] use_idx;
  bmd_prob_type use_prob;
  logic [2:0] events;

  // A read holds one wait state so its data come from settled registers.
  assign hreadyout_out = ~(ap_valid_r & ~ap_write_r & ~rd_done_r);
  assign hresp_out = 1'b0;
  assign hrdata_out = hrdata_r;
  assign take = hsel_in & hready_in & htrans_in[1];
  assign wr_cmt = ap_valid_r & ap_write_r;
  assign cmd_hit = wr_cmt & (ap_idx_r == `BMD_IDX_CMD);
  assign ready = (init_state_r == BMD_INIT_DONE);
  assign irq_out = |(irq_stat_r & irq_mask_r);
  assign drop_valid_out = drop_valid_r;
  assign drop_out = drop_r;

  // Address phase capture and read data selection.
  always_comb begin
    ap_valid_nxt = ap_valid_r;
    ap_write_nxt = ap_write_r;
    ap_idx_nxt = ap_idx_r;
    rd_done_nxt = rd_done_r;
    hrdata_nxt = hrdata_r;
    if (hreadyout_out) begin
      ap_valid_nxt = take & (haddr_in[31:16] == 16'h0000);
      ap_write_nxt = hwrite_in;
      ap_idx_nxt = haddr_in[15:2];
      rd_done_nxt = 1'b0;
    end else begin
      rd_done_nxt = 1'b1;
      case (ap_idx_r)
        `BMD_IDX_RST_STS: hrdata_nxt = {31'h0, ready};
        `BMD_IDX_CMD: hrdata_nxt = {27'h0, cmd_r};
        `BMD_IDX_WDATA: hrdata_nxt = {22'h0, wdata_r};
        `BMD_IDX_RDATA: hrdata_nxt = {22'h0, rdata_r};
        `BMD_IDX_ENABLE: hrdata_nxt = {31'h0, enable_r};
        `BMD_IDX_IRQ_STAT: hrdata_nxt = {29'h0, irq_stat_r};
        `BMD_IDX_IRQ_MASK: hrdata_nxt = {29'h0, irq_mask_r};
        default: hrdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_idx_r <= 14'h0000;
      rd_done_r <= 1'b0;
      hrdata_r <= 32'h0;
    end else begin
      ap_valid_r <= ap_valid_nxt;
      ap_write_r <= ap_write_nxt;
      ap_idx_r <= ap_idx_nxt;
      rd_done_r <= rd_done_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  // Register writes, table access launch and interrupt status.
  always_comb begin
    cmd_nxt = cmd_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    enable_nxt = enable_r;
    irq_mask_nxt = irq_mask_r;
    irq_stat_nxt = irq_stat_r;
    tbl_we = 1'b0;
    tbl_waddr = hwdata_in[3:0];
    if (wr_cmt) begin
      case (ap_idx_r)
        `BMD_IDX_WDATA: wdata_nxt = hwdata_in[`BMD_PROB_MSB:0];
        `BMD_IDX_ENABLE: enable_nxt = hwdata_in[0];
        `BMD_IDX_IRQ_MASK: irq_mask_nxt = hwdata_in[2:0];
        `BMD_IDX_IRQ_STAT: irq_stat_nxt = irq_stat_r & ~hwdata_in[2:0];
        default: ;
      endcase
    end
    if (cmd_hit) begin
      cmd_nxt = hwdata_in[4:0];
      if (hwdata_in[`BMD_CMD_RNW_BIT]) begin
        rdata_nxt = table_mem[hwdata_in[`BMD_CMD_IDX_MSB:0]];
      end else begin
        tbl_we = 1'b1;
      end
    end
    // Hardware events win over a same-cycle software clear.
    irq_stat_nxt = irq_stat_nxt | events;
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      cmd_r <= `BMD_CMD_RST;
      wdata_r <= `BMD_PROB_RST;
      rdata_r <= `BMD_PROB_RST;
      enable_r <= 1'b0;
      irq_stat_r <= 3'h0;
      irq_mask_r <= 3'h0;
    end else begin
      cmd_r <= cmd_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      enable_r <= enable_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
    end
  end

  // Table storage has no reset; contents are whatever software last wrote.
  always_ff @(posedge clk_in) begin
    if (tbl_we) begin
      table_mem[tbl_waddr] <= wdata_r;
    end
  end

  // Table initialisation sequencer, restarted by any fabric reset.
  always_comb begin
    init_state_nxt = init_state_r;
    init_cnt_nxt = init_cnt_r;
    init_ev = 1'b0;
    case (init_state_r)
      BMD_INIT_RUN: begin
        if (init_cnt_r == 16'(INIT_LAST)) begin
          init_state_nxt = BMD_INIT_DONE;
          init_ev = 1'b1;
        end else begin
          init_cnt_nxt = init_cnt_r + 16'h0001;
        end
      end
      BMD_INIT_DONE: init_cnt_nxt = init_cnt_r;
      default: init_state_nxt = BMD_INIT_RUN;
    endcase
    if (fabric_reset_in) begin
      init_state_nxt = BMD_INIT_RUN;
      init_cnt_nxt = 16'h0000;
      init_ev = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      init_state_r <= BMD_INIT_RUN;
      init_cnt_r <= 16'h0000;
    end else begin
      init_state_r <= init_state_nxt;
      init_cnt_r <= init_cnt_nxt;
    end
  end

  // Occupancy in 128-byte buffers picks an entry, finer at low usage.
  always_comb begin
    if (!port_buf_count_in[7] && !port_buf_count_in[6]) begin
      use_idx = {1'b0, port_buf_count_in[5:3]};
    end else if (!port_buf_count_in[7]) begin
      use_idx = {2'b10, port_buf_count_in[5:4]};
    end else begin
      use_idx = {2'b11, port_buf_count_in[6:5]};
    end
  end

  assign use_prob = table_mem[use_idx];
  assign events = {drop_nxt, cmd_hit, init_ev};

  // Yellow packets are dropped when a random draw falls below the entry.
  always_comb begin
    lfsr_nxt = {lfsr_r[8:0], lfsr_r[9] ^ lfsr_r[6]};
    drop_valid_nxt = pkt_valid_in;
    drop_nxt = pkt_valid_in & pkt_yellow_in & enable_r & ready
               & ((lfsr_r - 10'h001) < use_prob);
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      lfsr_r <= `BMD_LFSR_SEED;
      drop_valid_r <= 1'b0;
      drop_r <= 1'b0;
    end else begin
      lfsr_r <= lfsr_nxt;
      drop_valid_r <= drop_valid_nxt;
      drop_r <= drop_nxt;
    end
  end

  chk_ready_after_reset: assert property (@(posedge clk_in)
    $rose(reset_n_in) |-> !ready)
    else $error("Ready flag set right after reset.");

  chk_ready_after_count: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $rose(ready) |-> $past(init_cnt_r) == 16'(INIT_LAST))
    else $error("Ready flag rose before initialisation finished.");

  chk_fabric_rerun: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    fabric_reset_in |=> !ready)
    else $error("Fabric reset did not restart initialisation.");

  chk_cmd_fields: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    cmd_hit |=> cmd_r == $past(hwdata_in[4:0]))
    else $error("Command register did not take the written fields.");

  chk_table_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (cmd_hit && !hwdata_in[4]) |=> table_mem[$past(hwdata_in[3:0])] == $past(wdata_r))
    else $error("Write command did not store write data.");

  chk_read_entry: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (cmd_hit && hwdata_in[4]) |=> rdata_r == table_mem[$past(hwdata_in[3:0])])
    else $error("Read command did not present the entry.");

  chk_read_wait: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (hreadyout_out && ap_valid_nxt && !hwrite_in) |=> !hreadyout_out ##1 hreadyout_out)
    else $error("Read did not complete after exactly one wait state.");

  chk_rdata_upper: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (ap_valid_r && !ap_write_r && rd_done_r && ap_idx_r == `BMD_IDX_RDATA)
    |-> hrdata_out[31:10] == 22'h0 && hrdata_out[9:0] == rdata_r)
    else $error("Read-data register returned wrong bits.");

  chk_green_kept: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (pkt_valid_in && !pkt_yellow_in) |=> drop_valid_out && !drop_out)
    else $error("Non-yellow packet was dropped.");

endmodule : bmd_discard_table

// File: shared/bmd_params.svh
/*
  Constants for the buffer manager discard-table register bank.
  Assumes inclusion by bare name; word indices are byte address divided by four.
*/
`ifndef BMD_PARAMS_SVH
`define BMD_PARAMS_SVH

// Register word indices; byte address is four times the index.
`define BMD_IDX_RST_STS 14'h1c08
`define BMD_IDX_CMD 14'h1c09
`define BMD_IDX_WDATA 14'h1c0a
`define BMD_IDX_RDATA 14'h1c0b
`define BMD_IDX_ENABLE 14'h1c10
`define BMD_IDX_IRQ_STAT 14'h1c11
`define BMD_IDX_IRQ_MASK 14'h1c12

// Field positions.
`define BMD_RDY_BIT 0
`define BMD_CMD_RNW_BIT 4
`define BMD_CMD_IDX_MSB 3
`define BMD_PROB_MSB 9

// Reset values.
`define BMD_CMD_RST 5'h00
`define BMD_PROB_RST 10'h000
`define BMD_LFSR_SEED 10'h001

// Interrupt status bits.
`define BMD_EV_INIT 0
`define BMD_EV_ACCESS 1
`define BMD_EV_DROP 2

// Table initialisation time and its cycle count at 8 ns per cycle, rounded up.
`define BMD_CLK_PERIOD_NS 8
`define BMD_INIT_TIME_NS 4096
`define BMD_INIT_CYCLES ((`BMD_INIT_TIME_NS + `BMD_CLK_PERIOD_NS - 1) / `BMD_CLK_PERIOD_NS)

`endif

// File: shared/bmd_pkg.sv
/*
  Types for the buffer manager discard-table register bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package bmd_pkg;

  // Table initialisation sequencer states.
  typedef enum logic [0:0] {BMD_INIT_RUN, BMD_INIT_DONE} bmd_init_state_type;

  // One drop probability in units of 1/1023.
  typedef logic [9:0] bmd_prob_type;

endpackage : bmd_pkg

// File: testbench/test_buffer_mgr_discard_table_access.sv
/*
  Self-checking testbench for the discard-table register bank over AHB-Lite.
  Assumes bmd_pkg and bmd_discard_table are compiled first and bmd_params.svh is included.
*/
`timescale 1ns/1ns
`include "bmd_params.svh"

module test_buffer_mgr_discard_table_access import bmd_pkg::*; ;
  localparam int INIT_N = 16;
  localparam int LIMIT = 4000;
  typedef struct {logic [7:0] lo; logic [7:0] hi; bmd_prob_type prob;} bmd_row_type;
  logic clk_in = 1'h0;
  logic reset_n_in = 1'h0;
  logic hsel_in = 1'h0;
  logic [31:0] haddr_in = 32'h0;
  logic [1:0] htrans_in = 2'h0;
  logic hwrite_in = 1'h0;
  logic [2:0] hsize_in = 3'h2;
  logic [31:0] hwdata_in = 32'h0;
  logic fabric_reset_in = 1'h0;
  logic pkt_valid_in = 1'h0;
  logic pkt_yellow_in = 1'h0;
  logic [7:0] port_buf_count_in = 8'h0;
  logic [31:0] hrdata_out;
  logic hreadyout_out, hresp_out, drop_valid_out, drop_out, irq_out;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  bmd_row_type rows [16];

  // Device under test; the single slave drives the bus ready.
  bmd_discard_table #(.INIT_CYCLES(INIT_N)) u_bmd_discard_table (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
    .hready_in(hreadyout_out), .hwdata_in(hwdata_in), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .fabric_reset_in(fabric_reset_in),
    .pkt_valid_in(pkt_valid_in), .pkt_yellow_in(pkt_yellow_in),
    .port_buf_count_in(port_buf_count_in), .drop_valid_out(drop_valid_out),
    .drop_out(drop_out), .irq_out(irq_out));

  // Clock of 8 ns period.
  initial begin
    forever #4 clk_in = ~clk_in;
  end

  // Watchdog that cuts a hang short.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check_bit

  // Single word transfers; the master holds each phase until ready is sampled high.
  task automatic ahb_write(input logic [13:0] idx, input logic [31:0] data);
    hsel_in <= 1'h1;
    haddr_in <= {16'h0, idx, 2'h0};
    htrans_in <= 2'h2;
    hwrite_in <= 1'h1;
    do @(posedge clk_in); while (hreadyout_out !== 1'h1);
    htrans_in <= 2'h0;
    hwdata_in <= data;
    do @(posedge clk_in); while (hreadyout_out !== 1'h1);
  endtask : ahb_write

  task automatic ahb_read(input logic [13:0] idx, output logic [31:0] data);
    hsel_in <= 1'h1;
    haddr_in <= {16'h0, idx, 2'h0};
    htrans_in <= 2'h2;
    hwrite_in <= 1'h0;
    do @(posedge clk_in); while (hreadyout_out !== 1'h1);
    htrans_in <= 2'h0;
    do @(posedge clk_in); while (hreadyout_out !== 1'h1);
    data = hrdata_out;
  endtask : ahb_read

  task automatic read_check(input logic [13:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    ahb_read(idx, rd);
    check_word(rd, exp);
  endtask : read_check

  // One packet decision; the answer stands in the cycle after the request.
  task automatic send_pkt(input logic [7:0] cnt, input logic yel, input logic exp);
    pkt_valid_in <= 1'h1;
    pkt_yellow_in <= yel;
    port_buf_count_in <= cnt;
    @(posedge clk_in);
    pkt_valid_in <= 1'h0;
    @(posedge clk_in);
    check_bit(drop_valid_out, 1'h1);
    check_bit(drop_out, exp);
  endtask : send_pkt

  // Applies reset, checks idle outputs and reset values, then waits for the ready flag.
  task automatic do_reset();
    reset_n_in <= 1'h0;
    @(posedge clk_in);
    #1;
    check_word({hreadyout_out, hresp_out, drop_valid_out, drop_out, irq_out}, 32'h10);
    @(posedge clk_in);
    reset_n_in <= 1'h1;
    read_check(`BMD_IDX_RST_STS, 32'h0);
    read_check(`BMD_IDX_CMD, 32'h0);
    read_check(`BMD_IDX_WDATA, 32'h0);
    read_check(`BMD_IDX_RDATA, 32'h0);
    read_check(`BMD_IDX_IRQ_MASK, 32'h0);
    repeat (INIT_N + 4) @(posedge clk_in);
    read_check(`BMD_IDX_RST_STS, 32'h1);
    // The end of initialisation is the only event since reset cleared the status.
    read_check(`BMD_IDX_IRQ_STAT, 32'h1);
    $display("test reset done");
  endtask : do_reset

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence: a write-data and entry 0 round trip, rows of entries, then the awkward cases.
  initial begin
    for (int i = 0; i < 16; i++) begin
      rows[i].lo = (i < 8) ? 8'(i * 8) : (i < 12) ? 8'(64 + (i - 8) * 16) : 8'(128 + (i - 12) * 32);
      rows[i].hi = rows[i].lo + ((i < 8) ? 8'd7 : (i < 12) ? 8'd15 : 8'd31);
      rows[i].prob = i[0] ? 10'h3ff : 10'h000;
    end
    do_reset();
    ahb_write(`BMD_IDX_WDATA, 32'hffff_fea5);
    read_check(`BMD_IDX_WDATA, 32'h2a5);
    ahb_write(`BMD_IDX_CMD, 32'h0);
    ahb_write(`BMD_IDX_CMD, 32'h10);
    read_check(`BMD_IDX_RDATA, 32'h2a5);
    // All sixteen entries are programmed before discarding is enabled.
    for (int i = 0; i < 16; i++) begin
      ahb_write(`BMD_IDX_WDATA, {22'h0, rows[i].prob});
      ahb_write(`BMD_IDX_CMD, {27'h0, 1'h0, 4'(i)});
    end
    for (int i = 0; i < 16; i++) begin
      ahb_write(`BMD_IDX_CMD, {27'h0, 1'h1, 4'(i)});
      read_check(`BMD_IDX_RDATA, {22'h0, rows[i].prob});
    end
    ahb_write(`BMD_IDX_ENABLE, 32'h1);
    for (int i = 0; i < 16; i++) begin
      send_pkt(rows[i].lo, 1'h1, rows[i].prob[0]);
      send_pkt(rows[i].hi, 1'h1, rows[i].prob[0]);
    end
    send_pkt(8'hff, 1'h0, 1'h0);
    $display("test table rows done");
    ahb_write(`BMD_IDX_CMD, 32'hffff_fff3);
    read_check(`BMD_IDX_CMD, 32'h13);
    read_check(`BMD_IDX_RDATA, 32'h3ff);
    ahb_write(14'h1c20, 32'hffff_ffff);
    read_check(14'h1c20, 32'h0);
    // Interrupt: all three events seen, clear, raise by a command, mask and unmask.
    read_check(`BMD_IDX_IRQ_STAT, 32'h7);
    ahb_write(`BMD_IDX_IRQ_MASK, 32'h0);
    ahb_write(`BMD_IDX_IRQ_STAT, 32'h7);
    read_check(`BMD_IDX_IRQ_STAT, 32'h0);
    ahb_write(`BMD_IDX_CMD, 32'h12);
    read_check(`BMD_IDX_IRQ_STAT, 32'h2);
    check_bit(irq_out, 1'h0);
    ahb_write(`BMD_IDX_IRQ_MASK, 32'h2);
    // One more edge lets the new mask settle before the level is looked at.
    @(posedge clk_in);
    check_bit(irq_out, 1'h1);
    ahb_write(`BMD_IDX_IRQ_STAT, 32'h2);
    @(posedge clk_in);
    check_bit(irq_out, 1'h0);
    $display("test registers and interrupt done");
    // Fabric reset reruns the table initialisation.
    @(posedge clk_in);
    fabric_reset_in <= 1'h1;
    @(posedge clk_in);
    fabric_reset_in <= 1'h0;
    read_check(`BMD_IDX_RST_STS, 32'h0);
    repeat (INIT_N + 4) @(posedge clk_in);
    read_check(`BMD_IDX_RST_STS, 32'h1);
    do_reset();
    ahb_write(`BMD_IDX_CMD, 32'h11);
    read_check(`BMD_IDX_RDATA, 32'h3ff);
    $display("test fabric reset and second reset done");
    tally_and_finish();
  end
endmodule : test_buffer_mgr_discard_table_access
